// [design/gdf_monitor.sv]
// fault supervision for a three-phase gate driver
// Operation
// - sustained main supply overvoltage shuts drivers and pump, pin low, latched
// - gate supply undervoltage shuts down and pulls pin only when action bit is 1
// - sustained gate supply overvoltage shuts drivers and pump, pin low, latched
// - bootstrap undervoltage with action bit disables only that high side, pin low
// - bootstrap undervoltage flag stays latched after recovery only when hold bit set
// - sustained bootstrap overvoltage shuts drivers and pump, pin low, latched
// - charge pump under or overvoltage shuts drivers and pump, pin low, latched
// - drain supply undervoltage shuts drivers and pump, pin low, latched
// - drain supply overvoltage shuts down and latches, threshold chosen by software
// - gate commanded off with high gate voltage sets its flag, pin low
// - gate commanded on with low gate voltage sets its flag, pin low
// - gate monitor blanking and deglitch are software selectable
// - drain-source overcurrent past deglitch drives all gates low, pin low
// - shunt overcurrent past deglitch drives all gates low, pin low, latched
// - low-side pins may output phase comparators; host then uses mode 010
// - high-side input disagreeing with phase comparator sets per-phase mismatch flag
// - overtemperature in fault mode kills gates, pump, sensing; pin low, latched
// - overtemperature at power up in fault mode holds pin low until gone and cleared
// - thermal warning only sets a latched flag; pin stays high
// - after power up crc8 over memory sets failure flag on mismatch
// - watchdog off at start, counts when enabled, access must fall within window
// - watchdog violation sets watchdog fault bit and pulls pin low
`timescale 1ns/1ps
`default_nettype none
module gdf_monitor
	import gdf_pkg::*;
#(
	parameter int NWORDS = OTP_WORDS,
	parameter int WDT_LOW = WDT_LOW_CYC,
	parameter int WDT_HIGH = WDT_HIGH_CYC
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// comparator results and configuration
	input wire gdf_cmp_s cmp,
	input wire gdf_cfg_s cfg,
	// pwm inputs
	input wire logic [2:0] high_side_input,
	input wire logic [2:0] low_side_input,
	// host events
	input wire logic fault_clear_command,
	input wire logic spi_valid_access,
	// configuration memory read port
	output logic [$clog2(NWORDS)-1:0] otp_addr,
	input wire logic [7:0] otp_rdata,
	input wire logic [7:0] otp_stored_crc,
	// gate, pump and sense enables
	output logic [2:0] gate_hs_en,
	output logic [2:0] gate_ls_en,
	output logic pump_en,
	output logic sense_en,
	// phase comparator outputs on low-side pins
	output logic [2:0] low_side_pin_out,
	output logic [2:0] low_side_pin_oe_n,
	// status
	output logic fault_indicator_pin_n,
	output gdf_flags_s status,
	output logic crc_done
);

	localparam int NDG = 28;
	localparam int AW = $clog2(NWORDS);

	gdf_flags_s flags_r;
	gdf_flags_s flags_nxt;
	gdf_flags_s set_v;
	gdf_flags_s live_v;
	gdf_flags_s keep_v;
	gdf_crc_e crc_st_r;
	logic [NDG-1:0] dg_cond;
	logic [NDG-1:0] dg_hit;
	logic [5:0] vgs_cond;
	logic [5:0] cmd;
	logic [5:0] cmd_prev_r;
	logic [2:0] ls_cmd;
	logic [2:0] mism;
	logic [2:0] bst_block;
	logic [DG_W-1:0] blk_len;
	logic [DG_W-1:0] deg_len;
	logic [DG_W-1:0] ds_len;
	logic [DG_W-1:0] sh_len;
	logic [WDT_W-1:0] wdt_cnt_r;
	logic [7:0] crc_r;
	logic shut_all;
	logic ocp_off;
	logic ot_off;
	logic ot_now;
	logic pin_fault;
	logic crc_set_r;
	logic crc_fail_r;
	logic wdt_set_r;

	generate
		if (NWORDS < 2 || WDT_LOW < 1 || WDT_LOW >= WDT_HIGH || WDT_HIGH >= (1 << (WDT_W - 1)))
		begin : g_chk
			$error("gdf_monitor: unsupported parameter values");
		end
	endgenerate

	// selectable timer lengths
	assign blk_len = sel_cyc(GATE_MONITOR_BLANKING_NS[cfg.gate_monitor_blanking]);
	assign deg_len = sel_cyc(GATE_MONITOR_DEGLITCH_NS[cfg.gate_monitor_deglitch]);
	assign ds_len = sel_cyc(OCP_DEG_NS[cfg.ds_deglitch]);
	assign sh_len = sel_cyc(OCP_DEG_NS[cfg.shunt_deglitch]);

	// low side source: pins; when pins carry phase outputs, software in mode 010, else all off
	assign ls_cmd = !cfg.phase_out_enable ? low_side_input :
		(cfg.drive_mode == MODE_SPIN_3X) ? cfg.sw_low_side_en : 3'h0;
	assign cmd = {gate_ls_en, gate_hs_en};

	// remember last command for blanking restart
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			cmd_prev_r <= 6'h00;
		else
			cmd_prev_r <= cmd;
	end

	// per-gate blanking after each command edge
	generate
		for (genvar i = 0; i < 6; i++)
		begin : g_blank
			logic [DG_W-1:0] blank_r;
			always_ff @(posedge ref_clk or posedge rst)
			begin
				if (rst)
					blank_r <= '0;
				else if (cmd[i] != cmd_prev_r[i])
					blank_r <= blk_len;
				else if (blank_r != '0)
					blank_r <= blank_r - 1'b1;
			end
			// off gate must stay low, on gate must be enhanced
			assign vgs_cond[i] = (blank_r == '0) &&
				(cmd[i] ? !cmp.vgs_high[i] : cmp.vgs_high[i]);
		end
	endgenerate

	// deglitch inputs; supply thresholds picked by level bits
	assign dg_cond = {cmp.shunt_oc, cmp.ds_oc, vgs_cond, cmp.bst_ov, cmp.bst_uv,
		cmp.drain_ov[cfg.drain_supply_ov_level], cmp.drain_uv, cmp.pump_ov, cmp.pump_uv,
		cmp.gate_ov, cmp.gate_uv, cmp.main_ov[cfg.main_supply_ov_level]};

	// one deglitch timer per monitored condition
	generate
		for (genvar i = 0; i < NDG; i++)
		begin : g_dg
			logic [DG_W-1:0] len;
			assign len = (i >= 25) ? sh_len : (i >= 19) ? ds_len : (i >= 13) ? deg_len : SUP_LEN;
			gdf_deglitch #(
				.W(DG_W)
			) u_dg (
				.ref_clk(ref_clk),
				.rst(rst),
				.cond(dg_cond[i]),
				.len(len),
				.hit(dg_hit[i])
			);
		end
	endgenerate

	// phase comparator cross-check
	assign mism = high_side_input ^ cmp.phase;

	// power-up checksum walk over configuration memory
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			crc_st_r <= CRC_RUN;
			crc_r <= CRC_INIT;
			otp_addr <= '0;
			crc_set_r <= 1'b0;
			crc_fail_r <= 1'b0;
			crc_done <= 1'b0;
		end
		else
		begin
			crc_set_r <= 1'b0;
			case (crc_st_r)
				CRC_RUN:
				begin
					crc_r <= crc8_byte(crc_r, otp_rdata);
					otp_addr <= otp_addr + 1'b1;
					if (otp_addr == AW'(NWORDS - 1))
						crc_st_r <= CRC_CHECK;
				end
				CRC_CHECK:
				begin
					crc_fail_r <= (crc_r != otp_stored_crc);
					crc_set_r <= (crc_r != otp_stored_crc);
					crc_done <= 1'b1;
					crc_st_r <= CRC_IDLE;
				end
				default:
					crc_st_r <= CRC_IDLE;
			endcase
		end
	end

	// window watchdog on host accesses
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			wdt_cnt_r <= '0;
			wdt_set_r <= 1'b0;
		end
		else
		begin
			wdt_set_r <= 1'b0;
			if (!cfg.watchdog_enable_bit)
				wdt_cnt_r <= '0;
			else if (spi_valid_access)
			begin
				wdt_cnt_r <= '0;
				wdt_set_r <= (wdt_cnt_r < WDT_W'(WDT_LOW));
			end
			else if (wdt_cnt_r >= WDT_W'(WDT_HIGH - 1))
			begin
				wdt_cnt_r <= '0;
				wdt_set_r <= 1'b1;
			end
			else
				wdt_cnt_r <= wdt_cnt_r + 1'b1;
		end
	end

	// flag set, hold and selective clear; set wins over clear
	always_comb
	begin
		set_v = gdf_flags_s'({mism, dg_hit[27:7], crc_set_r, wdt_set_r, cmp.warm,
			cmp.overtemp, dg_hit[6:0]});
		live_v = gdf_flags_s'({mism, dg_cond[27:7], crc_fail_r, 1'b0, cmp.warm,
			cmp.overtemp, dg_cond[6:0]});
		keep_v = '1;
		keep_v.bst_uv = {3{cfg.bootstrap_uv_hold}};
		flags_nxt = gdf_flags_s'(set_v | (flags_r & keep_v &
			~({$bits(gdf_flags_s){fault_clear_command}} & ~live_v)));
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			flags_r <= '0;
		else
			flags_r <= flags_nxt;
	end

	assign status = flags_r;

	// shutdown classes
	assign ot_off = flags_r.overtemp && (cfg.overtemp_action == OT_FAULT_MODE);
	// raw overtemperature stops the stage before its flag has latched, e.g. at power up
	assign ot_now = ot_off | (cmp.overtemp && (cfg.overtemp_action == OT_FAULT_MODE));
	assign shut_all = flags_r.main_ov | flags_r.gate_ov | flags_r.pump_uv | flags_r.pump_ov |
		(flags_r.gate_uv & cfg.gate_supply_uv_action) | flags_r.drain_uv | flags_r.drain_ov |
		(|flags_r.bst_ov) | ot_off;
	assign ocp_off = |{flags_r.drain_source_overcurrent, flags_r.shunt_overcurrent};
	assign bst_block = flags_r.bst_uv & {3{cfg.bootstrap_uv_action}};
	assign pin_fault = shut_all | ocp_off | (|bst_block) | (|flags_r.gate_monitor_flag) |
		flags_r.watchdog_fault_bit;

	// registered gate, pump, sense and pin drive
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			gate_hs_en <= 3'h0;
			gate_ls_en <= 3'h0;
			pump_en <= 1'b0;
			sense_en <= 1'b0;
			fault_indicator_pin_n <= 1'b1;
		end
		else
		begin
			gate_hs_en <= high_side_input & ~bst_block & {3{~(shut_all | ocp_off | ot_now)}};
			gate_ls_en <= ls_cmd & {3{~(shut_all | ocp_off | ot_now)}};
			pump_en <= !(shut_all | ot_now);
			sense_en <= !ot_now;
			fault_indicator_pin_n <= !pin_fault;
		end
	end

	// phase comparator outputs driven onto low-side pins
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			low_side_pin_out <= 3'h0;
			low_side_pin_oe_n <= 3'h7;
		end
		else
		begin
			low_side_pin_out <= cmp.phase;
			low_side_pin_oe_n <= {3{~cfg.phase_out_enable}};
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	AST_MAIN_OV: assert property (flags_r.main_ov |=> !pump_en && !fault_indicator_pin_n &&
		gate_hs_en == 3'h0 && gate_ls_en == 3'h0)
		else $error("main supply overvoltage did not shut down");
	AST_GATE_UV: assert property (flags_r.gate_uv && cfg.gate_supply_uv_action |=>
		!pump_en && !fault_indicator_pin_n)
		else $error("gate supply undervoltage did not shut down");
	AST_GATE_OV: assert property (flags_r.gate_ov |=> !pump_en && gate_ls_en == 3'h0)
		else $error("gate supply overvoltage did not shut down");
	AST_BST_UV: assert property (flags_r.bst_uv[0] && cfg.bootstrap_uv_action |=>
		!gate_hs_en[0] && !fault_indicator_pin_n)
		else $error("bootstrap undervoltage left high side on");
	AST_BST_HOLD: assert property (!cfg.bootstrap_uv_hold |=>
		flags_r.bst_uv == $past(dg_hit[9:7]))
		else $error("bootstrap flag held without hold bit");
	AST_BST_OV: assert property (|flags_r.bst_ov |=> !pump_en && !fault_indicator_pin_n)
		else $error("bootstrap overvoltage did not shut down");
	AST_PUMP: assert property (flags_r.pump_uv || flags_r.pump_ov |=> !pump_en)
		else $error("charge pump fault did not stop pump");
	AST_DRAIN_UV: assert property (flags_r.drain_uv |=> !pump_en && gate_hs_en == 3'h0)
		else $error("drain undervoltage did not shut down");
	AST_DRAIN_OV: assert property (dg_hit[6] |=> flags_r.drain_ov ##1 !pump_en)
		else $error("drain overvoltage not latched");
	AST_VGS: assert property ((|dg_hit[18:13]) |=> ##1 !fault_indicator_pin_n)
		else $error("gate monitor fault did not pull pin");
	AST_DS: assert property ((|flags_r.drain_source_overcurrent) |=>
		gate_hs_en == 3'h0 && gate_ls_en == 3'h0 && !fault_indicator_pin_n)
		else $error("drain-source overcurrent left gates on");
	AST_SHUNT: assert property ((|flags_r.shunt_overcurrent) |=> gate_ls_en == 3'h0)
		else $error("shunt overcurrent left gates on");
	AST_PHASE_PIN: assert property (cfg.phase_out_enable |=> low_side_pin_oe_n == 3'h0)
		else $error("phase outputs not driven");
	AST_MISMATCH: assert property (mism[0] |=> flags_r.phase_mismatch_flag[0])
		else $error("phase mismatch not flagged");
	AST_OTSD: assert property (ot_off |=> !sense_en && !pump_en && !fault_indicator_pin_n)
		else $error("overtemperature did not shut down");
	AST_OTW: assert property (flags_r.thermal_warning_flag && !fault_clear_command |=>
		flags_r.thermal_warning_flag)
		else $error("thermal warning lost without clear");
	AST_CRC: assert property (crc_st_r == CRC_CHECK && crc_r != otp_stored_crc |->
		##2 flags_r.crc_fail)
		else $error("checksum failure not flagged");
	AST_WDT_RESTART: assert property (cfg.watchdog_enable_bit && spi_valid_access |=>
		wdt_cnt_r == '0)
		else $error("watchdog not restarted by access");
	AST_WDT_FAULT: assert property (wdt_set_r |=> flags_r.watchdog_fault_bit ##1
		!fault_indicator_pin_n)
		else $error("watchdog violation not reported");
	AST_CLEAR: assert property (fault_clear_command && !dg_cond[0] && !dg_hit[0] |=>
		!flags_r.main_ov)
		else $error("clear did not reset inactive flag");
	AST_PIN_HIGH: assert property (flags_r == '0 |=> fault_indicator_pin_n)
		else $error("pin low with no latched fault");

	COV_SHUT: cover property (flags_r.main_ov ##1 !pump_en);
	COV_VGS: cover property (|flags_r.gate_monitor_flag);
	COV_WDT: cover property (wdt_set_r);
	COV_CLEAR: cover property (!fault_indicator_pin_n ##1 fault_clear_command ##2 fault_indicator_pin_n);

endmodule
`default_nettype wire

// [design/gdf_pkg.sv]
// constants, carriers and state types for the gate driver fault monitor
package gdf_pkg;

	// clock and timer widths
	localparam int CLK_MHZ = 25;
	localparam int DG_W = 8;
	localparam int WDT_W = 26;
	localparam int OTP_WORDS = 16;

	// deglitch and blanking times in ns
	localparam int SUP_DG_NS = 10000;
	localparam int GATE_MONITOR_BLANKING_NS [4] = '{500, 1000, 2000, 4000};
	localparam int GATE_MONITOR_DEGLITCH_NS [4] = '{250, 500, 1000, 2000};
	localparam int OCP_DEG_NS [4] = '{1000, 2000, 4000, 8000};

	// watchdog window in ns
	localparam int WDT_LOW_NS = 100000;
	localparam int WDT_HIGH_NS = 1000000;

	// checksum and mode codes
	localparam logic [7:0] CRC_INIT = 8'hFF;
	localparam logic [7:0] CRC_POLY = 8'h2F;
	localparam logic [2:0] MODE_SPIN_3X = 3'h2;
	localparam logic OT_FAULT_MODE = 1'h0;

	// least time rounds up, longest time rounds down
	function automatic int cyc_ceil(input int ns);
		return (ns * CLK_MHZ + 999) / 1000;
	endfunction

	function automatic int cyc_floor(input int ns);
		return (ns * CLK_MHZ) / 1000;
	endfunction

	function automatic logic [DG_W-1:0] sel_cyc(input int ns);
		return DG_W'(cyc_ceil(ns));
	endfunction

	localparam logic [DG_W-1:0] SUP_LEN = sel_cyc(SUP_DG_NS);
	localparam int WDT_LOW_CYC = cyc_ceil(WDT_LOW_NS);
	localparam int WDT_HIGH_CYC = cyc_floor(WDT_HIGH_NS);

	// one byte step of the msb-first crc8
	function automatic logic [7:0] crc8_byte(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++)
			r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
		return r;
	endfunction

	typedef enum logic [1:0] {CRC_RUN, CRC_CHECK, CRC_IDLE} gdf_crc_e;

	// deglitch-free comparator results
	typedef struct packed {
		logic [1:0] main_ov;
		logic gate_uv;
		logic gate_ov;
		logic [2:0] bst_uv;
		logic [2:0] bst_ov;
		logic pump_uv;
		logic pump_ov;
		logic drain_uv;
		logic [1:0] drain_ov;
		logic [5:0] vgs_high;
		logic [5:0] ds_oc;
		logic [2:0] shunt_oc;
		logic overtemp;
		logic warm;
		logic [2:0] phase;
	} gdf_cmp_s;

	// software configuration
	typedef struct packed {
		logic main_supply_ov_level;
		logic drain_supply_ov_level;
		logic gate_supply_uv_action;
		logic bootstrap_uv_action;
		logic bootstrap_uv_hold;
		logic [1:0] gate_monitor_blanking;
		logic [1:0] gate_monitor_deglitch;
		logic [1:0] ds_deglitch;
		logic [1:0] shunt_deglitch;
		logic overtemp_action;
		logic watchdog_enable_bit;
		logic phase_out_enable;
		logic [2:0] drive_mode;
		logic [2:0] sw_low_side_en;
	} gdf_cfg_s;

	// latched status flags
	typedef struct packed {
		logic [2:0] phase_mismatch_flag;
		logic [2:0] shunt_overcurrent;
		logic [5:0] drain_source_overcurrent;
		logic [5:0] gate_monitor_flag;
		logic [2:0] bst_ov;
		logic [2:0] bst_uv;
		logic crc_fail;
		logic watchdog_fault_bit;
		logic thermal_warning_flag;
		logic overtemp;
		logic drain_ov;
		logic drain_uv;
		logic pump_ov;
		logic pump_uv;
		logic gate_ov;
		logic gate_uv;
		logic main_ov;
	} gdf_flags_s;

endpackage

// [design/gdf_deglitch.sv]
// deglitch timer for one comparator condition
`timescale 1ns/1ps
`default_nettype none
module gdf_deglitch
	import gdf_pkg::*;
#(
	parameter int W = DG_W
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// condition and its required length in cycles
	input wire logic cond,
	input wire logic [W-1:0] len,
	// qualified result
	output logic hit
);

	logic [W-1:0] cnt_r;

	generate
		if (W < 2)
		begin : g_chk
			$error("gdf_deglitch: width too small");
		end
	endgenerate

	// count only an uninterrupted condition
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			cnt_r <= '0;
		else if (!cond)
			cnt_r <= '0;
		else if (cnt_r < len)
			cnt_r <= cnt_r + 1'b1;
	end

	// result once the full length has passed
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			hit <= 1'b0;
		else
			hit <= cond && (cnt_r >= len);
	end

	AST_DG_DROP: assert property (@(posedge ref_clk) disable iff (rst) !cond |=> !hit)
		else $error("deglitch result without condition");
	AST_DG_FULL: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(hit) |-> $past(cond) && ($past(cnt_r) >= $past(len)))
		else $error("deglitch result before full length");

endmodule
`default_nettype wire

// [tb/gdf_host_model.sv]
// host controller and power stage model facing the fault monitor
`timescale 1ns/1ps
`default_nettype none
module gdf_host_model
	import gdf_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// stage feedback from the monitor
	input wire logic [2:0] gate_hs_en,
	input wire logic [2:0] gate_ls_en,
	input wire logic [2:0] low_side_pin_out,
	input wire logic [2:0] low_side_pin_oe_n,
	// defects injected by the bench
	input wire logic [2:0] phase_bad,
	input wire logic [5:0] vgs_bad,
	// host pins and stage sense
	output logic [2:0] high_side_input,
	output logic [2:0] low_side_input,
	output logic fault_clear_command,
	output logic spi_valid_access,
	output logic [2:0] phase,
	output logic [5:0] vgs_high
);
	logic [2:0] pwm_ls;

	// idle pins at time zero
	initial
	begin
		high_side_input = 3'h0;
		pwm_ls = 3'h0;
		fault_clear_command = 1'b0;
		spi_valid_access = 1'b0;
	end

	// low-side wire resolves host drive against the monitor's drive
	assign low_side_input = (low_side_pin_oe_n & pwm_ls) | (~low_side_pin_oe_n & low_side_pin_out);
	// switch node follows the commanded high side
	assign phase = high_side_input ^ phase_bad;
	// gate voltages settle to the enables unless a defect is injected
	assign vgs_high = {gate_ls_en, gate_hs_en} ^ vgs_bad;

	// pwm levels change after a falling edge
	task automatic set_pwm(input logic [2:0] hs, input logic [2:0] ls);
		@(negedge ref_clk);
		high_side_input = hs;
		pwm_ls = ls;
	endtask

	// one-cycle clear request
	task automatic clear;
		@(negedge ref_clk);
		fault_clear_command = 1'b1;
		@(negedge ref_clk);
		fault_clear_command = 1'b0;
	endtask

	// one-cycle valid access; the caller sets the spacing, inside the window or early on purpose
	task automatic access;
		@(negedge ref_clk);
		spi_valid_access = 1'b1;
		@(negedge ref_clk);
		spi_valid_access = 1'b0;
	endtask
endmodule
`default_nettype wire

// [tb/test_gdf_monitor.sv]
// self-checking bench for the gate driver fault monitor
`timescale 1ns/1ps
`default_nettype none
module test_gdf_monitor
	import gdf_pkg::*;
;
	localparam int LIMIT = 30000;
	typedef struct packed {gdf_cmp_s c; gdf_flags_s f; logic pin; logic pump;} gdf_row_s;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	gdf_cmp_s cmp_tb, cmp;
	gdf_cfg_s cfg;
	gdf_flags_s status;
	gdf_row_s r;
	logic [2:0] hsi, lsi, phase_bad, m_phase, ls_out, oe_n, hs_en, ls_en;
	logic [5:0] vgs_bad, m_vgs;
	logic clr, acc, pump_en, sense_en, pin_n, crc_done;
	logic [3:0] otp_addr;
	logic [7:0] otp_mem [16];
	logic [7:0] stored;
	int err_total = 0;
	int samples_checked = 0;
	int cyc = 0;

	// clock
	always #20 ref_clk = ~ref_clk;

	// stage feedback replaces the bench's phase and gate sense
	always_comb
	begin
		cmp = cmp_tb;
		cmp.phase = m_phase;
		cmp.vgs_high = m_vgs;
	end

	gdf_monitor #(.NWORDS(16), .WDT_LOW(4), .WDT_HIGH(40)) gdf_monitor_i (
		.ref_clk(ref_clk), .rst(rst), .cmp(cmp), .cfg(cfg),
		.high_side_input(hsi), .low_side_input(lsi),
		.fault_clear_command(clr), .spi_valid_access(acc),
		.otp_addr(otp_addr), .otp_rdata(otp_mem[otp_addr]), .otp_stored_crc(stored),
		.gate_hs_en(hs_en), .gate_ls_en(ls_en), .pump_en(pump_en), .sense_en(sense_en),
		.low_side_pin_out(ls_out), .low_side_pin_oe_n(oe_n),
		.fault_indicator_pin_n(pin_n), .status(status), .crc_done(crc_done));

	gdf_host_model host_i (
		.ref_clk(ref_clk), .gate_hs_en(hs_en), .gate_ls_en(ls_en),
		.low_side_pin_out(ls_out), .low_side_pin_oe_n(oe_n),
		.phase_bad(phase_bad), .vgs_bad(vgs_bad),
		.high_side_input(hsi), .low_side_input(lsi), .fault_clear_command(clr),
		.spi_valid_access(acc), .phase(m_phase), .vgs_high(m_vgs));

	task automatic cycles(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic chk_b(input logic [5:0] got, input logic [5:0] exp, input string m);
		samples_checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic chk_st(input gdf_flags_s got, input gdf_flags_s exp, input string m);
		samples_checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic do_reset;
		rst = 1'b1;
		cycles(3);
		rst = 1'b0;
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// reference checksum over the memory image
	function automatic logic [7:0] crc_ref();
		logic [7:0] c;
		c = CRC_INIT;
		for (int w = 0; w < 16; w++)
		begin
			c = c ^ otp_mem[w];
			for (int b = 0; b < 8; b++)
				c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction

	// one fault source per row, expected flags and outputs derived from it
	function automatic gdf_row_s row(input int i);
		gdf_row_s x;
		x = '0;
		case (i)
			0: x.c.main_ov[0] = 1'b1;
			1: x.c.gate_uv = 1'b1;
			2: x.c.gate_ov = 1'b1;
			3: x.c.bst_ov[1] = 1'b1;
			4: x.c.pump_uv = 1'b1;
			5: x.c.pump_ov = 1'b1;
			6: x.c.drain_uv = 1'b1;
			7: x.c.drain_ov[0] = 1'b1;
			8: x.c.ds_oc[4] = 1'b1;
			9: x.c.shunt_oc[2] = 1'b1;
			10: x.c.overtemp = 1'b1;
			default: x.c.warm = 1'b1;
		endcase
		x.f.main_ov = |x.c.main_ov;
		x.f.gate_uv = x.c.gate_uv;
		x.f.gate_ov = x.c.gate_ov;
		x.f.bst_ov = x.c.bst_ov;
		x.f.pump_uv = x.c.pump_uv;
		x.f.pump_ov = x.c.pump_ov;
		x.f.drain_uv = x.c.drain_uv;
		x.f.drain_ov = |x.c.drain_ov;
		x.f.drain_source_overcurrent = x.c.ds_oc;
		x.f.shunt_overcurrent = x.c.shunt_oc;
		x.f.overtemp = x.c.overtemp;
		x.f.thermal_warning_flag = x.c.warm;
		x.pin = x.c.warm;
		x.pump = x.c.warm | (|x.c.ds_oc) | (|x.c.shunt_oc);
		return x;
	endfunction

	// cycle budget guards against a hang
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t timeout", $time);
			summarize();
		end
	end

	// main sequence
	initial
	begin
		cmp_tb = '0;
		cfg = '0;
		cfg.gate_supply_uv_action = 1'b1;
		phase_bad = 3'h0;
		vgs_bad = 6'h0;
		for (int i = 0; i < 16; i++)
			otp_mem[i] = 8'(i * 37 + 5);
		stored = crc_ref();
		do_reset();
		cycles(24);
		chk_b(crc_done, 1'b1, "crc done");
		chk_b(status.crc_fail, 1'b0, "crc ok");
		for (int i = 0; i < 12; i++)
		begin
			r = row(i);
			cmp_tb = r.c;
			cycles(256);
			chk_st(status, r.f, "flag set");
			chk_b(pin_n, r.pin, "pin");
			chk_b(pump_en, r.pump, "pump");
			cmp_tb = '0;
			cycles(3);
			chk_st(status, r.f, "flag held");
			host_i.clear();
			cycles(3);
			chk_st(status, '0, "flag cleared");
			chk_b(pin_n, 1'b1, "pin released");
			$display("row %0d done", i);
		end
		cfg.main_supply_ov_level = 1'b1;
		cmp_tb.main_ov[1] = 1'b1;
		cycles(200);
		cmp_tb.main_ov[1] = 1'b0;
		cycles(1);
		cmp_tb.main_ov[1] = 1'b1;
		cycles(200);
		chk_b(status.main_ov, 1'b0, "early flag");
		cycles(60);
		chk_b(status.main_ov, 1'b1, "level flag");
		cmp_tb = '0;
		host_i.clear();
		cfg.gate_supply_uv_action = 1'b0;
		cmp_tb.gate_uv = 1'b1;
		cycles(260);
		chk_b(pin_n, 1'b1, "uv pin");
		chk_b(pump_en, 1'b1, "uv pump");
		cmp_tb = '0;
		host_i.clear();
		cfg.drain_supply_ov_level = 1'b1;
		cfg.overtemp_action = 1'b1;
		cmp_tb.drain_ov[0] = 1'b1;
		cmp_tb.overtemp = 1'b1;
		cycles(260);
		chk_b(status.drain_ov, 1'b0, "ov level low");
		chk_b({pin_n, pump_en, sense_en}, 3'h7, "ot flag mode");
		cmp_tb.drain_ov = 2'h2;
		cycles(260);
		chk_b({status.drain_ov, pump_en}, 2'h2, "ov level high");
		cmp_tb = '0;
		cfg.overtemp_action = OT_FAULT_MODE;
		host_i.clear();
		$display("deglitch and mode test done");
		cfg.bootstrap_uv_action = 1'b1;
		for (int h = 0; h < 2; h++)
		begin
			cfg.bootstrap_uv_hold = h[0];
			host_i.set_pwm(3'h1, 3'h2);
			cycles(100);
			chk_b(hs_en, 3'h1, "hs on");
			cmp_tb.bst_uv[0] = 1'b1;
			cycles(256);
			chk_b(hs_en, 3'h0, "hs off");
			chk_b(ls_en, 3'h2, "ls on");
			chk_b(pin_n, 1'b0, "bst pin");
			cmp_tb.bst_uv[0] = 1'b0;
			cycles(4);
			chk_b(status.bst_uv, {2'h0, h[0]}, "bst hold");
			host_i.clear();
			cycles(3);
		end
		$display("bootstrap test done");
		cfg.gate_monitor_deglitch = 2'h3;
		host_i.set_pwm(3'h1, 3'h0);
		cycles(200);
		vgs_bad = 6'h09;
		cycles(40);
		chk_b(status.gate_monitor_flag, 6'h00, "vgs early");
		cycles(20);
		chk_b(status.gate_monitor_flag, 6'h09, "vgs flag");
		chk_b(pin_n, 1'b0, "vgs pin");
		vgs_bad = 6'h0;
		host_i.clear();
		cycles(30);
		phase_bad = 3'h2;
		cycles(3);
		chk_b(status.phase_mismatch_flag, 3'h2, "phase flag");
		chk_b(pin_n, 1'b1, "phase pin");
		phase_bad = 3'h0;
		host_i.clear();
		host_i.set_pwm(3'h1, 3'h2);
		cycles(30);
		cmp_tb.ds_oc[3] = 1'b1;
		cycles(20);
		chk_b(hs_en, 3'h1, "ds early");
		cycles(10);
		chk_b({hs_en, ls_en}, 6'h00, "ds gates");
		chk_b(pin_n, 1'b0, "ds pin");
		cmp_tb = '0;
		host_i.clear();
		$display("gate monitor test done");
		cfg.phase_out_enable = 1'b1;
		cfg.drive_mode = MODE_SPIN_3X;
		cfg.sw_low_side_en = 3'h5;
		cycles(4);
		chk_b(oe_n, 3'h0, "pins driven");
		chk_b(ls_out, m_phase, "pins phase");
		chk_b(ls_en, 3'h5, "spin lows");
		cfg.drive_mode = 3'h0;
		cycles(3);
		chk_b(ls_en, 3'h0, "lows off");
		cfg.phase_out_enable = 1'b0;
		cycles(3);
		chk_b(oe_n, 3'h7, "pins released");
		cfg.watchdog_enable_bit = 1'b1;
		repeat (3)
		begin
			cycles(10);
			host_i.access();
		end
		chk_b(status.watchdog_fault_bit, 1'b0, "wdt window");
		host_i.access();
		cycles(4);
		chk_b(status.watchdog_fault_bit, 1'b1, "wdt early");
		chk_b(pin_n, 1'b0, "wdt pin");
		cfg.watchdog_enable_bit = 1'b0;
		host_i.clear();
		cycles(3);
		cfg.watchdog_enable_bit = 1'b1;
		cycles(45);
		chk_b(status.watchdog_fault_bit, 1'b1, "wdt late");
		cfg.watchdog_enable_bit = 1'b0;
		host_i.clear();
		$display("phase output and watchdog test done");
		stored = ~crc_ref();
		cmp_tb.overtemp = 1'b1;
		do_reset();
		cycles(1);
		chk_b({hs_en, pump_en, sense_en}, 5'h00, "hot first edge");
		cycles(259);
		chk_b({pin_n, pump_en, sense_en}, 6'h0, "hot start");
		host_i.clear();
		cycles(3);
		chk_b(pin_n, 1'b0, "hot clear");
		chk_b(status.crc_fail, 1'b1, "crc fail");
		cmp_tb.overtemp = 1'b0;
		cycles(3);
		chk_b(pin_n, 1'b0, "cool held");
		host_i.clear();
		cycles(3);
		chk_b(pin_n, 1'b1, "cool cleared");
		$display("power up test done");
		summarize();
	end
endmodule
`default_nettype wire
